// File: src/lbw_pkg.sv
// Purpose: Shared constants and types of the segment display bias and waveform driver
// Assumes: 100 MHz system clock, byte addresses on an Avalon-MM slave port
// Notes:   Registers are one aligned 32-bit word each, data in the low byte
package lbw_pkg;
   localparam int          CLK_PERIOD_NS   = 10;
   localparam int          ADDR_W          = 10;
   localparam logic [9:0]  OFS_CTRL0       = 10'h000;
   localparam logic [9:0]  OFS_CTRL1       = 10'h004;
   localparam logic [9:0]  OFS_CTRL2       = 10'h008;
   localparam logic [9:0]  OFS_STATUS      = 10'h00C;
   localparam logic [9:0]  OFS_DMEM        = 10'h100;
   localparam logic [7:0]  CTRL0_RST       = 8'h00;
   localparam logic [7:0]  CTRL1_RST       = 8'h00;
   localparam logic [7:0]  CTRL2_RST       = 8'h00;
   localparam logic [7:0]  CTRL1_MASK      = 8'hEF;
   localparam logic [7:0]  CTRL2_MASK      = 8'h17;
   // CTRL0 fields
   localparam int          B_ENABLE        = 0;
   localparam int          B_RSEL_LO       = 1;
   localparam int          B_PUMP_LO       = 4;
   localparam int          B_PUMP_HI       = 5;
   localparam int          B_KIND          = 6;
   localparam int          B_TYPE          = 7;
   // CTRL1 fields
   localparam int          B_RATIO_LO      = 0;
   localparam int          B_QCT_LO        = 5;
   // CTRL2 fields
   localparam int          B_BIAS          = 0;
   localparam int          B_DUTY_LO       = 1;
   localparam int          B_V1_PIN        = 4;
   // Timing and pin counts
   localparam int          PANEL_DIV       = 8;
   localparam int          RESET_DELAY_NS  = 1000;
   localparam int          STARTUP_NS      = 1000;
   localparam int          HOLD_CYCLES     =
      (RESET_DELAY_NS + STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          NUM_COM         = 8;
   localparam int          NUM_SEG         = 43;

   typedef enum logic [1:0] {
      DUTY_4 = 2'b00, DUTY_6 = 2'b01, DUTY_8 = 2'b10, DUTY_RSV = 2'b11
   } lbw_duty_t;

   typedef enum logic [1:0] {
      PUMP_EXT = 2'b00, PUMP_REF = 2'b01, PUMP_BAD = 2'b10, PUMP_VDD = 2'b11
   } lbw_pump_t;

   typedef enum logic [2:0] {
      LV_VSS = 3'h0, LV_VA = 3'h1, LV_VB = 3'h2, LV_VC = 3'h3, LV_VD = 3'h4
   } lbw_level_t;

   // Gray along FLOAT -> OFF -> RUN
   typedef enum logic [1:0] {
      ST_FLOAT = 2'b00, ST_OFF = 2'b01, ST_RUN = 2'b11
   } lbw_state_t;
endpackage // lbw_pkg

// File: src/lbw_driver.sv
// Purpose: Segment display driver: reset behaviour, bias selection, COM/SEG waveforms
// Assumes: Panel clock and reset pins are asynchronous and are synchronised here
// Notes:   Outputs are level codes per pin; the analog ladder and pump sit outside
//
// Summary of operation
// - Enable low without MCU reset: driver held in reset, all COM/SEG driven low.
// - Any MCU reset: driver reset, all COM/SEG outputs floating throughout.
// - After MCU reset, driver stays reset for reset delay plus startup time.
// - Watchdog time-out during idle or sleep is not an MCU reset here.
// - Duty sets number of commons and time slots per frame.
// - Type select bit picks type A or lower-frequency type B waveforms.
// - Waveforms keep every pixel's average DC at zero.
// - R-type third bias uses four levels; quarter bias adds VD.
// - Four-bit ratio selects VA from eight sixteenths to full panel supply.
// - Three-bit field selects the R-type bias resistor switched in.
// - R-type bias with display disabled switches off the resistor chain current.
// - Quick charge length at each common phase start set by three-bit field.
// - C-type pump source field picks external pin or internal source.
// - C-type source 00 (external pin) with the V1 pin bit clear enables the charge pump.
// - C-type bias is third bias only, four levels, any source.
// - Eight commons only with R-type; four and six with both.
// - Duty field: 00 four, 01 six, 10 eight (R-type), 11 reserved.
// - Bias bit 0 gives third bias; 1 gives quarter bias, R-type only.
// - Timing clock is panel clock divided by 8, running only when enabled.
// - Display memory bit 1 turns pixel on, 0 off; read automatically.
//
// The implementer's own choices: the register addresses and register access over Avalon-MM.
module lbw_driver #(
   parameter int NSEG = lbw_pkg::NUM_SEG,
   parameter int HOLD = lbw_pkg::HOLD_CYCLES
) (
   input  wire logic                              CLK_SYS,
   input  wire logic                              RESET,
   input  wire logic [lbw_pkg::ADDR_W-1:0]        AVS_ADDRESS,
   input  wire logic                              AVS_READ,
   input  wire logic                              AVS_WRITE,
   input  wire logic [31:0]                       AVS_WRITEDATA,
   input  wire logic [3:0]                        AVS_BYTEENABLE,
   output logic      [31:0]                       AVS_READDATA,
   output logic                                   AVS_WAITREQUEST,
   input  wire logic                              PANEL_CLOCK,
   input  wire logic                              MCU_RESET,
   input  wire logic                              WDT_SLEEP_RESET,
   output logic      [3*lbw_pkg::NUM_COM-1:0]     COM_LEVEL,
   output logic      [3*NSEG-1:0]                 SEG_LEVEL,
   output logic                                   PIN_OE,
   output logic      [3:0]                        VA_RATIO_SELECT,
   output logic      [2:0]                        BIAS_RESISTOR_SELECT,
   output logic                                   BIAS_CHAIN_ON,
   output logic                                   QUICK_CHARGE,
   output logic      [1:0]                        PUMP_SOURCE_SELECT,
   output logic                                   PUMP_ENABLE
);
   timeunit 1ns;
   timeprecision 1ps;
   import lbw_pkg::*;

   typedef struct packed {
      logic                       pclk_s1;
      logic                       pclk_s2;
      logic                       pclk_d;
      logic                       mrst_s1;
      logic                       mrst_s2;
      logic                       wdt_s1;
      logic                       wdt_s2;
      logic [7:0]                 ctrl0;
      logic [7:0]                 ctrl1;
      logic [7:0]                 ctrl2;
      logic [NSEG-1:0][7:0]       dmem;
      logic                       ack;
      logic [31:0]                rdata;
      lbw_state_t                 st;
      logic [15:0]                hold;
      logic [2:0]                 div;
      logic [2:0]                 slot;
      logic                       half;
      logic                       pol;
      logic [3:0]                 qc;
      logic [3*NUM_COM-1:0]       com_lv;
      logic [3*NSEG-1:0]          seg_lv;
      logic                       oe;
      logic                       qca;
   } lbw_core_t;

   lbw_core_t core;
   lbw_core_t next_core;

   // Byte address to display memory index, or -1 when outside it
   function automatic int dmem_index(input logic [ADDR_W-1:0] a);
      int idx;
      idx = -1;
      if (a >= OFS_DMEM && a < OFS_DMEM + ADDR_W'(4 * NSEG) && a[1:0] == 2'b00) begin
         idx = int'(a - OFS_DMEM) / 4;
      end
      return idx;
   endfunction

   // Numerator of a bias fraction to level code
   function automatic logic [2:0] to_level(input logic [2:0] num, input logic quarter);
      logic [2:0] lv;
      lv = LV_VA;
      if (quarter) begin
         case (num)
            3'h0:    lv = LV_VSS;
            3'h1:    lv = LV_VD;
            3'h2:    lv = LV_VC;
            3'h3:    lv = LV_VB;
            default: lv = LV_VA;
         endcase
      end else begin
         case (num)
            3'h0:    lv = LV_VSS;
            3'h1:    lv = LV_VC;
            3'h2:    lv = LV_VB;
            default: lv = LV_VA;
         endcase
      end
      return lv;
   endfunction

   logic       rtype;
   logic       quarter;
   logic [2:0] ncom_m1;
   logic [7:0] cmask;
   logic       mcu_rst;
   logic       req;
   logic       tick;
   logic       pedge;
   logic [2:0] den;
   logic       cpos;
   logic [2:0] next_slot;
   logic       slot_start;
   int         widx;

   always_comb begin
      rtype   = ~core.ctrl0[B_KIND];
      quarter = core.ctrl2[B_BIAS] & rtype;
      case (lbw_duty_t'(core.ctrl2[B_DUTY_LO +: 2]))
         DUTY_6:  ncom_m1 = 3'h5;
         DUTY_8:  ncom_m1 = rtype ? 3'h7 : 3'h3;
         default: ncom_m1 = 3'h3;
      endcase
      cmask   = 8'hFF >> (3'h7 - ncom_m1);
      mcu_rst = core.mrst_s2 & ~core.wdt_s2;
      req     = AVS_READ | AVS_WRITE;
      widx    = dmem_index(AVS_ADDRESS);
      den     = quarter ? 3'h4 : 3'h3;
      pedge   = core.pclk_s2 & ~core.pclk_d & core.ctrl0[B_ENABLE];
      tick    = pedge && core.div == 3'(PANEL_DIV - 1);
      cpos    = core.ctrl0[B_TYPE] ? core.pol : ~core.half;
      next_slot  = (core.slot >= ncom_m1) ? 3'h0 : core.slot + 3'h1;
      slot_start = tick && (core.ctrl0[B_TYPE] || core.half);
   end

   always_comb begin
      next_core = core;
      next_core.pclk_s1 = PANEL_CLOCK;
      next_core.pclk_s2 = core.pclk_s1;
      next_core.pclk_d  = core.pclk_s2;
      next_core.mrst_s1 = MCU_RESET;
      next_core.mrst_s2 = core.mrst_s1;
      next_core.wdt_s1  = WDT_SLEEP_RESET;
      next_core.wdt_s2  = core.wdt_s1;

      // Bus slave: one wait cycle, write lands when waitrequest is low
      next_core.ack = req & ~core.ack;
      if (req && !core.ack) begin
         next_core.rdata = 32'h0000_0000;
         if (AVS_ADDRESS == OFS_CTRL0) begin
            next_core.rdata[7:0] = core.ctrl0;
         end else if (AVS_ADDRESS == OFS_CTRL1) begin
            next_core.rdata[7:0] = core.ctrl1;
         end else if (AVS_ADDRESS == OFS_CTRL2) begin
            next_core.rdata[7:0] = core.ctrl2;
         end else if (AVS_ADDRESS == OFS_STATUS) begin
            next_core.rdata[7:0] = {core.pol, core.slot, core.half, core.qca, core.st};
         end else if (widx >= 0) begin
            next_core.rdata[7:0] = core.dmem[widx] & cmask;
         end
      end
      if (AVS_WRITE && core.ack && AVS_BYTEENABLE[0]) begin
         if (AVS_ADDRESS == OFS_CTRL0) begin
            next_core.ctrl0 = AVS_WRITEDATA[7:0];
         end else if (AVS_ADDRESS == OFS_CTRL1) begin
            next_core.ctrl1 = AVS_WRITEDATA[7:0] & CTRL1_MASK;
         end else if (AVS_ADDRESS == OFS_CTRL2) begin
            next_core.ctrl2 = AVS_WRITEDATA[7:0] & CTRL2_MASK;
         end else if (widx >= 0) begin
            next_core.dmem[widx] = AVS_WRITEDATA[7:0];
         end
      end

      // Driver state
      case (core.st)
         ST_FLOAT: begin
            if (mcu_rst) begin
               next_core.hold = 16'(HOLD);
            end else if (core.hold != 16'h0000) begin
               next_core.hold = core.hold - 16'h0001;
            end else begin
               next_core.st = core.ctrl0[B_ENABLE] ? ST_RUN : ST_OFF;
            end
         end
         ST_OFF: begin
            if (core.ctrl0[B_ENABLE]) begin
               next_core.st = ST_RUN;
            end
         end
         default: begin
            if (!core.ctrl0[B_ENABLE]) begin
               next_core.st = ST_OFF;
            end
         end
      endcase
      if (mcu_rst) begin
         next_core.st   = ST_FLOAT;
         next_core.hold = 16'(HOLD);
      end

      // Frame timing
      if (core.st != ST_RUN) begin
         next_core.div  = 3'h0;
         next_core.slot = 3'h0;
         next_core.half = 1'b0;
         next_core.pol  = 1'b0;
         next_core.qc   = 4'h0;
      end else begin
         if (pedge) begin
            next_core.div = core.div + 3'h1;
            if (core.qc != 4'h0) begin
               next_core.qc = core.qc - 4'h1;
            end
         end
         if (tick) begin
            next_core.half = core.ctrl0[B_TYPE] ? 1'b0 : ~core.half;
         end
         if (slot_start) begin
            next_core.slot = next_slot;
            next_core.qc   = {1'b0, core.ctrl1[B_QCT_LO +: 3]} + 4'h1;
            if (next_slot == 3'h0) begin
               next_core.pol = ~core.pol;
            end
         end
      end
      next_core.qca = rtype && core.ctrl0[B_RSEL_LO + 2] && core.st == ST_RUN
                      && core.qc != 4'h0;

      // Pin levels
      next_core.oe = core.st != ST_FLOAT;
      for (int i = 0; i < NUM_COM; i++) begin
         next_core.com_lv[3*i +: 3] = LV_VSS;
         if (core.st == ST_RUN && 3'(i) <= ncom_m1) begin
            if (3'(i) == core.slot) begin
               next_core.com_lv[3*i +: 3] = to_level(cpos ? den : 3'h0, quarter);
            end else begin
               next_core.com_lv[3*i +: 3] = to_level(cpos ? 3'h1 : den - 3'h1,
                                                     quarter);
            end
         end
      end
      for (int s = 0; s < NSEG; s++) begin
         next_core.seg_lv[3*s +: 3] = LV_VSS;
         if (core.st == ST_RUN) begin
            if (core.dmem[s][core.slot]) begin
               next_core.seg_lv[3*s +: 3] = to_level(cpos ? 3'h0 : den, quarter);
            end else begin
               next_core.seg_lv[3*s +: 3] = to_level(cpos ? 3'h2 : den - 3'h2,
                                                     quarter);
            end
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         core       <= '0;
         core.ctrl0 <= CTRL0_RST;
         core.ctrl1 <= CTRL1_RST;
         core.ctrl2 <= CTRL2_RST;
         core.st    <= ST_FLOAT;
         core.hold  <= 16'(HOLD);
      end else begin
         core <= next_core;
      end
   end

   // Register-backed outputs; waitrequest decoded from the bus request
   assign AVS_READDATA         = core.rdata;
   assign AVS_WAITREQUEST      = req & ~core.ack;
   assign COM_LEVEL            = core.com_lv;
   assign SEG_LEVEL            = core.seg_lv;
   assign PIN_OE               = core.oe;
   assign VA_RATIO_SELECT      = core.ctrl1[B_RATIO_LO +: 4];
   assign BIAS_RESISTOR_SELECT = core.ctrl0[B_RSEL_LO +: 3];
   assign BIAS_CHAIN_ON        = rtype & (core.st == ST_RUN);
   assign QUICK_CHARGE         = core.qca;
   assign PUMP_SOURCE_SELECT   = core.ctrl0[B_PUMP_LO +: 2];
   assign PUMP_ENABLE          = ~rtype & (core.st == ST_RUN)
                                 & (lbw_pump_t'(core.ctrl0[B_PUMP_LO +: 2]) == PUMP_EXT)
                                 & ~core.ctrl2[B_V1_PIN];
endmodule // lbw_driver

// File: verification/lbw_driver_assertions.sv
// Purpose: Port checks of the segment display driver
// Assumes: Control bytes tracked from accepted bus writes
// Notes:   Settled means 80 cycles without a bus write
module lbw_driver_assertions #(
   parameter int NSEG = lbw_pkg::NUM_SEG,
   parameter int HOLD = lbw_pkg::HOLD_CYCLES
) (
   input wire logic                          CLK_SYS,
   input wire logic                          RESET,
   input wire logic [lbw_pkg::ADDR_W-1:0]    AVS_ADDRESS,
   input wire logic                          AVS_WRITE,
   input wire logic [31:0]                   AVS_WRITEDATA,
   input wire logic [3:0]                    AVS_BYTEENABLE,
   input wire logic                          AVS_WAITREQUEST,
   input wire logic                          MCU_RESET,
   input wire logic                          WDT_SLEEP_RESET,
   input wire logic [3*lbw_pkg::NUM_COM-1:0] COM_LEVEL,
   input wire logic [3*NSEG-1:0]             SEG_LEVEL,
   input wire logic                          PIN_OE,
   input wire logic                          BIAS_CHAIN_ON,
   input wire logic                          PUMP_ENABLE
);
   timeunit 1ns;
   timeprecision 1ps;
   import lbw_pkg::*;
   logic [7:0] c0, c2, quiet;
   logic       settled, vd, few;
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         c0    <= CTRL0_RST;
         c2    <= CTRL2_RST;
         quiet <= 8'h00;
      end else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0]) begin
         quiet <= 8'h00;
         if (AVS_ADDRESS == OFS_CTRL0) c0 <= AVS_WRITEDATA[7:0];
         if (AVS_ADDRESS == OFS_CTRL2) c2 <= AVS_WRITEDATA[7:0] & CTRL2_MASK;
      end else if (quiet != 8'hFF) begin
         quiet <= quiet + 8'h01;
      end
   end
   always_comb begin
      vd = 1'b0;
      for (int i = 0; i < NUM_COM; i++) vd = vd | (COM_LEVEL[3*i+:3] >= 3'h4);
      for (int s = 0; s < NSEG; s++) vd = vd | (SEG_LEVEL[3*s+:3] >= 3'h4);
   end
   assign settled = (quiet >= 8'h50);
   assign few     = (c2[2:1] != 2'b01) && (c2[2:1] != 2'b10 || c0[B_KIND]);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RESET);
   mcu_float_a : assert property ((MCU_RESET && !WDT_SLEEP_RESET)[*5] |-> !PIN_OE)
      else $error("pins driven in reset");
   rst_hold_a : assert property ($fell(RESET) |-> !PIN_OE[*3] ##[1:1000] PIN_OE)
      else $error("bad restart after reset");
   wdt_mask_a : assert property (PIN_OE ##1 (MCU_RESET && WDT_SLEEP_RESET)[*6] |-> PIN_OE)
      else $error("sleep watchdog floated pins");
   off_low_a : assert property (settled && !c0[B_ENABLE] && PIN_OE
      |-> !(|COM_LEVEL) && !(|SEG_LEVEL))
      else $error("disabled pins not low");
   four_com_a : assert property (settled && few |-> COM_LEVEL[23:12] == 12'h000)
      else $error("unused common driven");
   third_bias_a : assert property (settled && (c0[B_KIND] || !c2[B_BIAS]) |-> !vd)
      else $error("fifth level in third bias");
   chain_off_a : assert property (c0[B_KIND] || (settled && !c0[B_ENABLE]) |-> !BIAS_CHAIN_ON)
      else $error("bias chain left on");
   pump_on_a : assert property (settled && PIN_OE && !MCU_RESET
      |-> PUMP_ENABLE == (c0[B_KIND] && c0[B_ENABLE] && c0[5:4] == 2'b00 && !c2[B_V1_PIN]))
      else $error("pump enable wrong");
endmodule // lbw_driver_assertions

bind lbw_driver lbw_driver_assertions #(.NSEG(NSEG), .HOLD(HOLD)) i_lbw_driver_assertions (
   .CLK_SYS(CLK_SYS), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS), .AVS_WRITE(AVS_WRITE),
   .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
   .AVS_WAITREQUEST(AVS_WAITREQUEST), .MCU_RESET(MCU_RESET), .WDT_SLEEP_RESET(WDT_SLEEP_RESET),
   .COM_LEVEL(COM_LEVEL), .SEG_LEVEL(SEG_LEVEL), .PIN_OE(PIN_OE),
   .BIAS_CHAIN_ON(BIAS_CHAIN_ON), .PUMP_ENABLE(PUMP_ENABLE));

// File: verification/lbw_panel_model.sv
// Purpose: Passive panel measuring two pixels on common 0
// Assumes: Segment 0 lit on common 0, segment 1 dark
// Notes:   Samples each system clock while pins are driven
module lbw_panel_model #(
   parameter int NSEG = 4
) (
   input  wire logic                          clk,
   input  wire logic                          clr,
   input  wire logic [3*lbw_pkg::NUM_COM-1:0] com_level,
   input  wire logic [3*NSEG-1:0]             seg_level,
   input  wire logic                          pin_oe,
   input  wire logic                          quarter,
   output int                                 dc_off,
   output int                                 sq_on,
   output int                                 sq_off,
   output int                                 moves,
   output logic      [7:0]                    seen_mask,
   output logic                               seen_vd
);
   timeunit 1ns;
   timeprecision 1ps;
   import lbw_pkg::*;
   int         v_on, v_off;
   logic [2:0] prev;
   // Level code to voltage in steps of the top level over the bias divisor
   function automatic int volt(input logic [2:0] code, input logic q);
      return (code == 3'h0) ? 0 : (q ? 5 : 4) - int'(code);
   endfunction
   assign v_on  = volt(com_level[2:0], quarter) - volt(seg_level[2:0], quarter);
   assign v_off = volt(com_level[2:0], quarter) - volt(seg_level[5:3], quarter);
   always @(posedge clk) begin
      prev <= com_level[2:0];
      if (clr) begin
         dc_off    <= 0;
         sq_on     <= 0;
         sq_off    <= 0;
         moves     <= 0;
         seen_mask <= 8'h00;
         seen_vd   <= 1'b0;
      end else if (pin_oe) begin
         dc_off <= dc_off + v_off;
         sq_on  <= sq_on + v_on * v_on;
         sq_off <= sq_off + v_off * v_off;
         moves  <= moves + int'(com_level[2:0] != prev);
         for (int i = 0; i < NUM_COM; i++) begin
            if (com_level[3*i+:3] != 3'h0) seen_mask[i] <= 1'b1;
         end
         if (com_level[2:0] == 3'h4) seen_vd <= 1'b1;
      end
   end
endmodule // lbw_panel_model

// File: verification/lbw_driver_tb_top.sv
// Purpose: Self-checking bench of the segment display driver
// Assumes: Short hold and four segments keep the run brief
// Notes:   Panel clock is the system clock divided by four
module lbw_driver_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import lbw_pkg::*;
   localparam int NS = 4;
   localparam int HD = 4;
   localparam logic [31:0] TAB [6] = '{32'h01000F00, 32'h01023F00, 32'h0105FF01,
                                       32'h01060F00, 32'h41050F00, 32'h41023F00};
   logic            clk_sys, reset, rd, wr, mcu_rst, wdt_rst, clr, bias4;
   logic [9:0]      addr;
   logic [31:0]     wdata, rdata;
   logic [3:0]      be, ratio;
   logic            wait_req, oe, chain_on, qc, pump_en;
   logic [23:0]     com_lv;
   logic [3*NS-1:0] seg_lv;
   logic [2:0]      rsel;
   logic [1:0]      psrc, pdiv;
   logic [7:0]      seen_mask;
   logic            seen_vd;
   int              error_cnt, compares, dc_off, sq_on, sq_off, moves;
   lbw_driver #(.NSEG(NS), .HOLD(HD)) i_lbw_driver (.CLK_SYS(clk_sys), .RESET(reset),
      .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
      .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
      .PANEL_CLOCK(pdiv[1]), .MCU_RESET(mcu_rst), .WDT_SLEEP_RESET(wdt_rst),
      .COM_LEVEL(com_lv), .SEG_LEVEL(seg_lv), .PIN_OE(oe), .VA_RATIO_SELECT(ratio),
      .BIAS_RESISTOR_SELECT(rsel), .BIAS_CHAIN_ON(chain_on), .QUICK_CHARGE(qc),
      .PUMP_SOURCE_SELECT(psrc), .PUMP_ENABLE(pump_en));
   lbw_panel_model #(.NSEG(NS)) i_lbw_panel_model (.clk(clk_sys), .clr(clr),
      .com_level(com_lv), .seg_level(seg_lv), .pin_oe(oe), .quarter(bias4), .dc_off(dc_off),
      .sq_on(sq_on), .sq_off(sq_off), .moves(moves), .seen_mask(seen_mask), .seen_vd(seen_vd));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) pdiv <= pdiv + 2'h1;
   task automatic cycles(int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic chk_val(string what, logic [31:0] exp, logic [31:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic bus(logic w, logic [9:0] a, logic [7:0] d, output logic [31:0] q);
      addr  <= a;
      wdata <= {24'h000000, d};
      rd    <= !w;
      wr    <= w;
      do begin
         @(posedge clk_sys);
      end while (wait_req !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic wr_reg(logic [9:0] a, logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd_chk(logic [9:0] a, logic [7:0] exp, string what);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      chk_val(what, {24'h000000, exp}, q);
   endtask
   task automatic pulse_clr();
      clr <= 1'b1;
      @(posedge clk_sys);
      clr <= 1'b0;
   endtask
   task automatic t_reset_state();
      chk_val("pins in hold", 32'h0, 32'(oe));
      cycles(HD + 8);
      chk_val("pins after hold", 32'h1, 32'(oe));
      chk_val("commons off", 32'h0, 32'(com_lv));
      chk_val("segments off", 32'h0, 32'(seg_lv));
      rd_chk(OFS_CTRL0, CTRL0_RST, "ctrl0");
      rd_chk(OFS_CTRL2, CTRL2_RST, "ctrl2");
      wr_reg(10'h040, 8'h5A);
      rd_chk(10'h040, 8'h00, "unmapped");
   endtask
   task automatic t_regs();
      int n;
      wr_reg(OFS_CTRL1, 8'hFF);
      rd_chk(OFS_CTRL1, 8'hEF, "ctrl1");
      chk_val("va ratio", 32'hF, 32'(ratio));
      wr_reg(OFS_CTRL0, 8'h47);
      cycles(20);
      chk_val("resistor select", 32'h3, 32'(rsel));
      chk_val("pump on", 32'h1, 32'(pump_en));
      chk_val("chain in c kind", 32'h0, 32'(chain_on));
      wr_reg(OFS_CTRL0, 8'h77);
      chk_val("pump source", 32'h3, 32'(psrc));
      chk_val("pump off", 32'h0, 32'(pump_en));
      wr_reg(OFS_CTRL0, 8'h09);
      chk_val("chain on", 32'h1, 32'(chain_on));
      while (qc === 1'b1) @(negedge clk_sys);
      while (qc !== 1'b1) @(negedge clk_sys);
      n = 0;
      while (qc === 1'b1) begin
         @(negedge clk_sys);
         n++;
      end
      chk_val("quick charge cycles", 32'd32, 32'(n));
      @(posedge clk_sys);
      wr_reg(OFS_CTRL0, 8'h08);
      cycles(20);
      chk_val("chain off", 32'h0, 32'(chain_on));
   endtask
   task automatic t_wave(logic [7:0] c0, int bound, output int mv);
      wr_reg(OFS_CTRL0, c0);
      cycles(100);
      pulse_clr();
      cycles(2048);
      mv = moves;
      chk_val("dc within bound", 32'h1, 32'(dc_off <= bound && dc_off >= -bound));
      chk_val("on above off", 32'h1, 32'(sq_on > 2 * sq_off));
   endtask
   task automatic t_waves();
      int ma, mb;
      wr_reg(OFS_CTRL2, 8'h00);
      wr_reg(OFS_DMEM, 8'hF1);
      wr_reg(OFS_DMEM + 10'h004, 8'h00);
      rd_chk(OFS_DMEM, 8'h01, "display memory");
      t_wave(8'h01, 200, ma);
      t_wave(8'h81, 512, mb);
      chk_val("type b slower", 32'h1, 32'(mb < ma));
   endtask
   task automatic t_duty();
      for (int i = 0; i < 6; i++) begin
         bias4 <= TAB[i][16] & ~TAB[i][30];
         wr_reg(OFS_CTRL2, TAB[i][23:16]);
         wr_reg(OFS_CTRL0, TAB[i][31:24]);
         cycles(100);
         pulse_clr();
         cycles(700);
         chk_val("commons used", 32'(TAB[i][15:8]), 32'(seen_mask));
         chk_val("fifth level", 32'(TAB[i][0]), 32'(seen_vd));
      end
   endtask
   task automatic t_mcu();
      mcu_rst <= 1'b1;
      cycles(20);
      chk_val("float in reset", 32'h0, 32'(oe));
      mcu_rst <= 1'b0;
      cycles(2);
      chk_val("float after reset", 32'h0, 32'(oe));
      cycles(HD + 12);
      chk_val("driven after restart", 32'h1, 32'(oe));
      rd_chk(OFS_CTRL0, 8'h41, "ctrl0 kept");
      wdt_rst <= 1'b1;
      mcu_rst <= 1'b1;
      cycles(20);
      chk_val("driven in sleep watchdog", 32'h1, 32'(oe));
      mcu_rst <= 1'b0;
      cycles(1);
      wdt_rst <= 1'b0;
      cycles(20);
      chk_val("driven after watchdog", 32'h1, 32'(oe));
   endtask
   task automatic tally_and_finish();
      if (error_cnt == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      {bias4, rd, wr, mcu_rst, wdt_rst, clr, reset} = 7'h01;
      addr      = 10'h000;
      wdata     = 32'h0;
      be        = 4'h1;
      pdiv      = 2'h0;
      error_cnt = 0;
      compares  = 0;
      cycles(12);
      reset <= 1'b0;
      @(posedge clk_sys);
      t_reset_state();
      t_regs();
      t_waves();
      t_duty();
      t_mcu();
      tally_and_finish();
   end
   initial begin
      #400000;
      error_cnt++;
      tally_and_finish();
   end
endmodule // lbw_driver_tb_top
